// ### hw/gd_host_pkg.sv
// Purpose: shared constants for the gate driver host controller
// Assumes: 250 MHz system clock, 32-bit register port
// Notes: register offsets are byte addresses on the plain register port

package gd_host_pkg;
	// clock and port widths
	localparam int CLK_MHZ = 250;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// timing: the driver drops pulses under this width, so ours must be longer
	localparam int PULSE_MIN_NS = 40;
	localparam int PULSE_MARGIN_CYC = 2;
	localparam int FAULT_MUTE_NS_DEF = 1000;

	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

	// control bits
	localparam int CTRL_W = 4;
	localparam int CTRL_EN = 0;
	localparam int CTRL_INV = 1;
	localparam int CTRL_ILK = 2;
	localparam int CTRL_AUTO = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// command bits
	localparam int CMD_CLEAR = 0;

	// status bits
	localparam int ST_FAULT = 0;
	localparam int ST_GOOD = 1;
	localparam int ST_LATCHED = 2;
	localparam int ST_PEND = 3;

	// interrupt events
	localparam int IRQ_W = 4;
	localparam int EV_FAULT_SET = 0;
	localparam int EV_FAULT_REL = 1;
	localparam int EV_GOOD_LOST = 2;
	localparam int EV_GOOD_BACK = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// fault handling states
	typedef enum logic [1:0] {
		ST_RUN,
		ST_MUTE,
		ST_WAIT,
		ST_PULSE
	} fsm_state_t;
endpackage

// ### hw/gate_drive_host.sv
// Purpose: host controller for an isolated gate driver: pwm pins, enable/reset, fault clear
// Assumes: fault and supply-good lines arrive synchronous, pulled up externally
// Notes: all pins are driven push-pull from flops, so none ever floats
// Functional notes
// RL1 - driver drops pulses under 40 ns
// RL2 - both pwm inputs high forces output low
// RL3 - interlock: opposite switch pwm onto inverting input
// RL4 - never float inputs; unused inverting input low
// RL5 - fault and supply-good are open-drain lines
// RL6 - enable pin pulled down inside driver
// RL7 - output enabled only while enable pin high
// RL8 - fault latches output low until reset
// RL9 - reset pulse only after fault mute time
// RL10 - automatic reset: pwm fed onto enable pin
// RL11 - overcurrent switches off and pulls fault low
// RL12 - undervoltage holds output low, supply-good low
// RL13 - cleared fault releases flag, output follows pwm
//
// Our own choices: the plain strobed port and the placing of the registers.

`timescale 1ns/1ns
`default_nettype none

module gate_drive_host #(
	parameter int FAULT_MUTE_NS = gd_host_pkg::FAULT_MUTE_NS_DEF,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [gd_host_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [gd_host_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [gd_host_pkg::DATA_W-1:0] reg_rdata_out,
	output logic irq_out,
	// pwm sources from the modulator
	input wire logic pwm_own_in,
	input wire logic pwm_opp_in,
	// driver pins
	output logic in_pos_out,
	output logic in_neg_out,
	output logic reset_enable_out,
	input wire logic fault_flag_n_in,
	input wire logic supply_good_in
);
	import gd_host_pkg::*;

	// pulse longer than the driver's deglitch window, rounded up
	localparam logic [CNT_W-1:0] PULSE_CYC =
		CNT_W'((PULSE_MIN_NS * CLK_MHZ + 999) / 1000 + PULSE_MARGIN_CYC); // RL1
	localparam logic [CNT_W-1:0] MUTE_CYC = CNT_W'((FAULT_MUTE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic rst_meta_q;
	logic rst_sync_q;
	fsm_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic in_pos_q, in_pos_d;
	logic in_neg_q, in_neg_d;
	logic rst_en_q, rst_en_d;
	logic pulse_start;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic clr_pend_q, clr_pend_d;
	logic fault_prev_q, good_prev_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic [IRQ_W-1:0] ev;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic fault_seen;
	logic pwm_go;

	// reset release through two flops; the first is read only by the second
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// fault flag is open-drain: low means the driver latched a fault
	assign fault_seen = ~fault_flag_n_in; // RL5
	// drive only while running with a good supply; a latched driver ignores pwm anyway
	assign pwm_go = ctrl_q[CTRL_EN] && (state_q == ST_RUN) && supply_good_in; // RL12

	// fault handling sequence and pin values
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		pulse_start = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (fault_seen) begin // RL11
					state_d = ST_MUTE;
					cnt_d = MUTE_CYC;
				end
			end
			ST_MUTE: begin
				if (cnt_q <= CNT_ONE) begin // RL9
					state_d = ST_WAIT;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			ST_WAIT: begin
				if (!fault_seen) begin // RL13
					state_d = ST_RUN;
				end else if (clr_pend_q && !ctrl_q[CTRL_AUTO]) begin
					state_d = ST_PULSE;
					cnt_d = PULSE_CYC;
					pulse_start = 1'b1;
				end
			end
			ST_PULSE: begin
				// back to wait: the flag release decides when we run again
				if (cnt_q <= CNT_ONE) begin
					state_d = ST_WAIT;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			default: begin
				state_d = ST_RUN;
				cnt_d = '0;
			end
		endcase
		// inverting mode parks the noninverting pin high and drives the inverted pwm
		if (ctrl_q[CTRL_INV]) begin
			in_pos_d = 1'b1;
			in_neg_d = pwm_go ? ~pwm_own_in : 1'b1;
		end else begin
			in_pos_d = pwm_go & pwm_own_in;
			in_neg_d = ctrl_q[CTRL_ILK] ? pwm_opp_in : 1'b0; // RL3 RL4 RL2
		end
		// enable pin: low disables, and a low pulse after the mute time clears a fault
		case (state_q)
			ST_MUTE: rst_en_d = 1'b1; // RL9
			ST_PULSE: rst_en_d = 1'b0; // RL8
			ST_WAIT: rst_en_d = ctrl_q[CTRL_AUTO] ? pwm_own_in : 1'b1; // RL10
			ST_RUN: begin
				if (fault_seen) begin
					rst_en_d = 1'b1; // RL9
				end else if (ctrl_q[CTRL_EN]) begin
					rst_en_d = ctrl_q[CTRL_AUTO] ? pwm_own_in : 1'b1; // RL10 RL7
				end else begin
					rst_en_d = 1'b0; // RL6 RL7
				end
			end
			default: rst_en_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_RUN;
			cnt_q <= '0;
			in_pos_q <= 1'b0;
			in_neg_q <= 1'b0;
			rst_en_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			in_pos_q <= in_pos_d;
			in_neg_q <= in_neg_d;
			rst_en_q <= rst_en_d;
		end
	end

	// line edges become interrupt events
	assign ev[EV_FAULT_SET] = fault_prev_q & ~fault_flag_n_in;
	assign ev[EV_FAULT_REL] = ~fault_prev_q & fault_flag_n_in;
	assign ev[EV_GOOD_LOST] = good_prev_q & ~supply_good_in;
	assign ev[EV_GOOD_BACK] = ~good_prev_q & supply_good_in;

	// register file: writes, read data one cycle later, read-to-clear status
	always_comb begin
		ctrl_d = ctrl_q;
		irq_mask_d = irq_mask_q;
		clr_pend_d = clr_pend_q & ~pulse_start;
		irq_stat_d = irq_stat_q;
		rdata_d = '0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				OFS_CTRL: ctrl_d = reg_wdata_in[CTRL_W-1:0];
				OFS_IRQ_MASK: irq_mask_d = reg_wdata_in[IRQ_W-1:0];
				// a command landing with the pulse start stays pending: set wins
				OFS_CMD: clr_pend_d = clr_pend_d | reg_wdata_in[CMD_CLEAR];
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
				OFS_STATUS: begin
					rdata_d[ST_FAULT] = fault_seen;
					rdata_d[ST_GOOD] = supply_good_in;
					rdata_d[ST_LATCHED] = (state_q != ST_RUN);
					rdata_d[ST_PEND] = clr_pend_q;
				end
				OFS_IRQ_STAT: begin
					rdata_d[IRQ_W-1:0] = irq_stat_q;
					irq_stat_d = '0;
				end
				OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
				default: rdata_d = '0;
			endcase
		end
		// events set after the clear so a coincident edge is kept
		irq_stat_d = irq_stat_d | ev;
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctrl_q <= CTRL_RST;
			irq_mask_q <= IRQ_RST;
			irq_stat_q <= IRQ_RST;
			clr_pend_q <= 1'b0;
			rdata_q <= '0;
			irq_q <= 1'b0;
			fault_prev_q <= 1'b1;
			good_prev_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			irq_mask_q <= irq_mask_d;
			irq_stat_q <= irq_stat_d;
			clr_pend_q <= clr_pend_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			fault_prev_q <= fault_flag_n_in;
			good_prev_q <= supply_good_in;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;
	assign in_pos_out = in_pos_q;
	assign in_neg_out = in_neg_q;
	assign reset_enable_out = rst_en_q;

	// checks on pin behaviour
	property p_mute_hold;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(state_q == ST_MUTE) |-> rst_en_q;
	endproperty
	a_mute_hold: assert property (p_mute_hold) else $error("enable pin low during mute"); // RL9

	property p_fault_mute;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		($fell(fault_flag_n_in) && state_q == ST_RUN) |=> rst_en_q [*8];
	endproperty
	a_fault_mute: assert property (p_fault_mute) else $error("reset sent inside mute time"); // RL9

	property p_clear_pulse;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(state_q == ST_WAIT && fault_seen && clr_pend_q && !ctrl_q[CTRL_AUTO])
			|=> ##1 (!rst_en_q) [*8];
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too short"); // RL9

	property p_tie_low;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(!ctrl_q[CTRL_INV] && !ctrl_q[CTRL_ILK]) |=> !in_neg_q;
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("unused inverting pin not low"); // RL4

	property p_interlock;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(!ctrl_q[CTRL_INV] && ctrl_q[CTRL_ILK]) |=> (in_neg_q == $past(pwm_opp_in));
	endproperty
	a_interlock: assert property (p_interlock) else $error("opposite pwm not on pin"); // RL3

	property p_auto_reset;
		@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(state_q == ST_WAIT && ctrl_q[CTRL_AUTO]) |=> (rst_en_q == $past(pwm_own_in));
	endproperty
	a_auto_reset: assert property (p_auto_reset) else $error("enable pin not following pwm"); // RL10

	// main scenarios
	c_manual_clear: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_q)
		state_q == ST_PULSE ##[1:100] state_q == ST_RUN);
	c_auto_clear: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_q)
		(state_q == ST_WAIT && ctrl_q[CTRL_AUTO]) ##1 state_q == ST_RUN);
	c_good_lost: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_q)
		ev[EV_GOOD_LOST] ##1 irq_q);
endmodule // gate_drive_host

`default_nettype wire

// ### testbench/gd_device_model.sv
// Purpose: behavioural model of the isolated gate driver input side
// Assumes: sampled on the system clock, 10 cycles are 40 ns at 250 MHz
// Notes: status lines come out as pull enables, the bench adds pull-ups
`timescale 1ns/1ns
`default_nettype none

module gd_device_model #(
	parameter int FILT = 10
) (
	// clock
	input wire logic clk_in,
	// driver pins: [0] noninverting, [1] inverting, [2] reset/enable
	input wire logic [2:0] pin_in,
	// faults commanded by the bench
	input wire logic oc_in,
	input wire logic uv_in,
	// open-drain pulls and gate
	output logic flt_oe_out,
	output logic rdy_oe_out,
	output logic gate_drive_out
);
	logic [2:0] filt_q = 3'h0; // enable starts low as if pulled down
	int cnt_q[3] = '{0, 0, 0};
	logic latch_q = 1'b0;

	// a level counts only once stable for FILT cycles, so short pulses vanish
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 3; i++) begin
			if (pin_in[i] == filt_q[i])
				cnt_q[i] <= 0;
			else if (cnt_q[i] == FILT - 1) begin
				filt_q[i] <= pin_in[i];
				cnt_q[i] <= 0;
			end else
				cnt_q[i] <= cnt_q[i] + 1;
		end
	end

	// overcurrent latch, cleared only by a filtered low on reset/enable
	always_ff @(posedge clk_in) begin
		if (oc_in)
			latch_q <= 1'b1;
		else if (!filt_q[2])
			latch_q <= 1'b0;
	end

	// open-drain pulls and gate output
	assign flt_oe_out = latch_q;
	assign rdy_oe_out = uv_in;
	assign gate_drive_out = filt_q[2] & ~latch_q & ~uv_in & filt_q[0] & ~filt_q[1];
endmodule // gd_device_model

`default_nettype wire

// ### testbench/tb.sv
// Purpose: self-checking bench of the gate driver host controller
// Assumes: driver model on the far side, pull-ups on its status lines
// Notes: mute time shortened to 40 ns so a fault clears quickly
`timescale 1ns/1ns
`default_nettype none

module tb;
	import gd_host_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic own = 1'b0;
	logic opp = 1'b0; // opposite pwm always driven
	logic oc = 1'b0;
	logic uv = 1'b0;
	logic [31:0] rdata;
	logic irq, ipos, ineg, ren, flt_oe, rdy_oe, gate;
	int bad_count = 0;
	int total_checks = 0;
	int n;
	int cyc = 0;

	// status lines are open drain with pull-ups: high unless pulled
	gate_drive_host #(.FAULT_MUTE_NS(40)) i_dut (.clk_sys_in(clk), .rst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .irq_out(irq), .pwm_own_in(own), .pwm_opp_in(opp),
		.in_pos_out(ipos), .in_neg_out(ineg), .reset_enable_out(ren),
		.fault_flag_n_in(~flt_oe), .supply_good_in(~rdy_oe));
	gd_device_model i_dev (.clk_in(clk), .pin_in({ren, ineg, ipos}), .oc_in(oc), .uv_in(uv),
		.flt_oe_out(flt_oe), .rdy_oe_out(rdy_oe), .gate_drive_out(gate));

	// clock and hang guard
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// bus cycles start on an edge so strobes never change twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wait_ren(input logic v);
		n = 0;
		while (ren !== v && n < 300) begin
			tick(1);
			n++;
		end
	endtask

	task automatic t_reset();
		chk(ren, 1'b0);
		// a write to an unmapped offset must not reach the control register
		wr_reg(8'h14, 32'hF);
		rd_chk(OFS_CTRL, 32'h0);
		rd_chk(OFS_IRQ_MASK, 32'h0);
		rd_chk(OFS_STATUS, 32'h2);
		rd_chk(OFS_IRQ_STAT, 32'h8);
		rd_chk(OFS_IRQ_STAT, 32'h0);
		rd_chk(8'h14, 32'h0);
	endtask

	task automatic t_pwm();
		wr_reg(OFS_CTRL, 32'h1);
		own <= 1'b1;
		tick(16);
		chk(gate, 1'b1);
		wr_reg(OFS_CTRL, 32'h5);
		opp <= 1'b1;
		tick(16);
		chk(ineg, 1'b1);
		chk(gate, 1'b0);
		wr_reg(OFS_CTRL, 32'h0);
		opp <= 1'b0;
		tick(14);
		chk(ren, 1'b0);
		chk(gate, 1'b0);
	endtask

	task automatic t_inv();
		wr_reg(OFS_CTRL, 32'h3);
		own <= 1'b0;
		tick(16);
		chk({ipos, ineg, gate}, 3'h6);
		@(posedge clk);
		own <= 1'b1;
		tick(16);
		chk({ipos, ineg, gate}, 3'h5);
	endtask

	task automatic t_fault();
		wr_reg(OFS_CTRL, 32'h1);
		wr_reg(OFS_IRQ_MASK, 32'h1);
		tick(14);
		@(posedge clk);
		oc <= 1'b1;
		@(posedge clk);
		oc <= 1'b0;
		wr_reg(OFS_CMD, 32'h1);
		tick(1);
		chk({irq, gate}, 2'h2);
		rd_chk(OFS_STATUS, 32'hF);
		wait_ren(1'b0);
		chk(n >= 5, 1'b1);
		wait_ren(1'b1);
		chk(n >= 10, 1'b1);
		tick(14);
		chk({flt_oe, gate}, 2'h1);
		rd_chk(OFS_IRQ_STAT, 32'h3);
		rd_chk(OFS_IRQ_STAT, 32'h0);
		tick(1);
		chk(irq, 1'b0);
	endtask

	task automatic t_uvlo();
		// unmask supply loss as well so its interrupt is seen
		wr_reg(OFS_IRQ_MASK, 32'h5);
		@(posedge clk);
		uv <= 1'b1;
		tick(3);
		chk({irq, gate}, 2'h2);
		rd_chk(OFS_STATUS, 32'h0);
		@(posedge clk);
		uv <= 1'b0;
		tick(14);
		chk(gate, 1'b1);
		rd_chk(OFS_IRQ_STAT, 32'hC);
		chk(irq, 1'b0);
	endtask

	task automatic t_auto();
		wr_reg(OFS_CTRL, 32'h9);
		own <= 1'b0;
		tick(3);
		chk(ren, 1'b0);
		@(posedge clk);
		own <= 1'b1;
		tick(3);
		chk(ren, 1'b1);
		// fault in auto mode: pin held high through the mute, then a low pwm clears it
		@(posedge clk);
		oc <= 1'b1;
		@(posedge clk);
		oc <= 1'b0;
		own <= 1'b0;
		tick(6);
		chk({irq, ren, flt_oe}, 3'h7);
		tick(30);
		chk({flt_oe, ren, gate}, 3'h0);
		@(posedge clk);
		own <= 1'b1;
		tick(14);
		chk({flt_oe, ren, gate}, 3'h3);
	endtask

	// reset for three cycles, then the scenarios in turn
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		tick(4);
		t_reset();
		t_pwm();
		t_inv();
		t_fault();
		t_uvlo();
		t_auto();
		test_done();
	end
endmodule // tb

`default_nettype wire
